/* design/bcr_pkg.sv */
// shared constants and carrier types for the bus command receiver
package bcr_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned BIT_NS       = 8000;  // command_bit_period
  localparam int unsigned BIT_CYC      = (BIT_NS * CLK_MHZ) / 1000;
  localparam int unsigned VALID_NS     = 1000;  // least low time to qualify
  localparam int unsigned VALID_CYC    = (VALID_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W        = 10;
  localparam int unsigned LONG_W       = 24;

  // ----------------------------------------------------------------
  // command lengths in bits per mode
  // ----------------------------------------------------------------
  localparam logic [5:0] BITS_DISC     = 6'h01;
  localparam logic [5:0] BITS_CRM      = 6'h20;
  localparam logic [5:0] BITS_PDCM     = 6'h04;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_CMD       = 8'h08;
  localparam logic [7:0] OFS_COUNT     = 8'h0c;
  localparam logic [7:0] OFS_VREF      = 8'h10;
  localparam logic [2:0] CTRL_RESET    = 3'h0;   // discovery, receiver off
  localparam int unsigned CTRL_EN_BIT  = 2;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_DECERR   = 2'h3;

  // ----------------------------------------------------------------
  // reference averaging
  // ----------------------------------------------------------------
  localparam int unsigned AVG_SHIFT    = 4;
  localparam logic [9:0] LOW_MARGIN    = 10'h020;

  typedef enum logic [1:0] {
    BCR_MODE_DISC = 2'h0,
    BCR_MODE_CRM  = 2'h1,
    BCR_MODE_PDCM = 2'h2,
    BCR_MODE_BDM  = 2'h3
  } bcr_mode_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } bcr_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bcr_axi_rsp_t;

  typedef struct packed {
    logic start;
    logic valid;
    logic block;
    logic sample;
  } bcr_flags_t;

endpackage

/* design/bcr_vhigh_avg.sv */
// low-pass average of the bus high level and low-level decision
`timescale 1ns/100ps
module bcr_vhigh_avg
  import bcr_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // sampling control and supply level
  input  wire logic       sample_en,
  input  wire logic [9:0] supply_code,
  // averaged reference and decision
  output logic [9:0]      ref_code,
  output logic            low_det
);

  logic [13:0] acc_reg;
  logic [13:0] acc_next;
  logic        low_reg;
  logic [10:0] supply_sum;

  // ----------------------------------------------------------------
  // averaging
  // ----------------------------------------------------------------
  // first-order filter: acc += x - acc/16, held while sampling is off
  assign acc_next   = sample_en ? 14'(acc_reg + {4'h0, supply_code}
                                      - {4'h0, acc_reg[13:AVG_SHIFT]})
                                : acc_reg;
  assign supply_sum = {1'b0, supply_code} + {1'b0, LOW_MARGIN};
  assign ref_code   = acc_reg[13:AVG_SHIFT];
  assign low_det    = low_reg;

  // accumulator and low-level decision against the average
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= 14'h0000;
      low_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      low_reg <= supply_sum < {1'b0, ref_code};
    end
  end

endmodule

/* design/bcr_receiver.sv */
// bus command receiver front end with axi4-lite register slave
`timescale 1ns/100ps
// Function
// - a low comparator level marks the possible start of a command
// - comparator feeds a counter on the clock; the valid flag and each received bit come from its value
// - start flag asserts when the counter reaches one
// - start clears at reset or when validity count is missed within one bit
// - start also clears when the mode's lockout interval ends
// - valid flag asserts when validity count is reached within one bit
// - valid and block flags clear at reset and whenever start clears
// - sample enable sets after reset delay and on start clear, clears on start
// - block flag asserts once the mode's complete command has arrived
// - a complete command is handed on with a one-cycle strobe
// - high level averaged only while sampling; low decision uses that average
module bcr_receiver
  import bcr_pkg::*;
#(
  parameter int unsigned POR_DELAY_NS = 1000000,
  parameter int unsigned LOCK_DISC_NS = 400000,
  parameter int unsigned LOCK_CRM_NS  = 300000,
  parameter int unsigned LOCK_PDCM_NS = 60000,
  parameter int unsigned LOCK_BDM_NS  = 60000
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // register bus
  input  wire bcr_axi_req_t axi_req,
  output bcr_axi_rsp_t     axi_rsp,
  // bus comparator and supply level
  input  wire logic        bus_cmp_n,
  input  wire logic [9:0]  supply_code,
  // receiver flags and reference
  output bcr_flags_t       rx_flags,
  output logic [9:0]       vhigh_ref,
  output logic             supply_low,
  // command hand-off to the link layer
  output logic             cmd_done,
  output logic [31:0]      cmd_word,
  output bcr_mode_t        cmd_mode
);

  // ----------------------------------------------------------------
  // derived counts
  // ----------------------------------------------------------------
  localparam logic [LONG_W-1:0] POR_CYC =
    LONG_W'((POR_DELAY_NS * CLK_MHZ) / 1000);
  localparam logic [LONG_W-1:0] LOCK_DISC_CYC =
    LONG_W'((LOCK_DISC_NS * CLK_MHZ) / 1000);
  localparam logic [LONG_W-1:0] LOCK_CRM_CYC =
    LONG_W'((LOCK_CRM_NS * CLK_MHZ) / 1000);
  localparam logic [LONG_W-1:0] LOCK_PDCM_CYC =
    LONG_W'((LOCK_PDCM_NS * CLK_MHZ) / 1000);
  localparam logic [LONG_W-1:0] LOCK_BDM_CYC =
    LONG_W'((LOCK_BDM_NS * CLK_MHZ) / 1000);
  localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] VALID_TOP = CNT_W'(VALID_CYC);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic              cmp_s1_reg;
  logic              cmp_s2_reg;
  logic              start_reg;
  logic              valid_reg;
  logic              block_reg;
  logic              sample_reg;
  logic [CNT_W-1:0]  qual_cnt_reg;
  logic [CNT_W-1:0]  qual_cnt_next;
  logic [CNT_W-1:0]  win_cnt_reg;
  logic [LONG_W-1:0] lock_cnt_reg;
  logic [LONG_W-1:0] por_cnt_reg;
  logic              por_done_reg;
  logic [5:0]        bits_cnt_reg;
  logic [31:0]       shift_reg;
  logic [31:0]       shift_next;
  logic              done_reg;
  logic [31:0]       cmd_reg;
  logic [2:0]        ctrl_reg;
  logic [15:0]       good_cnt_reg;
  logic [15:0]       bad_cnt_reg;
  logic              bus_low;
  logic              rx_en;
  bcr_mode_t         mode;
  logic              start_set;
  logic              valid_set;
  logic              win_fail;
  logic              lock_end;
  logic              start_clr;
  logic              bit_end;
  logic              bit_val;
  logic              bit_take;
  logic              cmd_full;
  logic              por_hit;
  logic [5:0]        bits_need;
  logic [LONG_W-1:0] lock_len;
  // bus slave
  logic              aw_hold_reg;
  logic [7:0]        aw_addr_reg;
  logic              w_hold_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic              do_write;
  logic              wr_ctrl;
  logic              wr_count;
  logic              wr_hit;
  logic              rd_hit;
  logic [31:0]       rd_mux;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // comparator pin is asynchronous: two flops before any use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_s1_reg <= 1'b1;
      cmp_s2_reg <= 1'b1;
    end else begin
      cmp_s1_reg <= bus_cmp_n;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // lockout length and command size per operating mode
  assign rx_en     = ctrl_reg[CTRL_EN_BIT];
  assign mode      = bcr_mode_t'(ctrl_reg[1:0]);
  assign bits_need = (mode == BCR_MODE_DISC) ? BITS_DISC :
                     (mode == BCR_MODE_CRM)  ? BITS_CRM  : BITS_PDCM;
  assign lock_len  = (mode == BCR_MODE_DISC) ? LOCK_DISC_CYC :
                     (mode == BCR_MODE_CRM)  ? LOCK_CRM_CYC  :
                     (mode == BCR_MODE_PDCM) ? LOCK_PDCM_CYC : LOCK_BDM_CYC;

  // ----------------------------------------------------------------
  // qualification decode
  // ----------------------------------------------------------------
  // low comparator level
  assign bus_low   = ~cmp_s2_reg;
  assign start_set = ~start_reg & rx_en & bus_low;
  assign bit_end   = start_reg & (win_cnt_reg == BIT_LAST);
  assign valid_set = start_reg & ~valid_reg & bus_low
                   & (qual_cnt_reg == VALID_TOP - 1'b1);
  assign win_fail  = bit_end & ~valid_reg & ~valid_set;
  assign lock_end  = start_reg & (lock_cnt_reg == lock_len - 1'b1);
  assign start_clr = win_fail | lock_end;
  // a bit is a one when it held a qualified low
  assign bit_val   = (qual_cnt_reg >= VALID_TOP) | valid_set;
  assign bit_take  = bit_end & (valid_reg | valid_set) & ~block_reg & ~start_clr;
  assign shift_next = {shift_reg[30:0], bit_val};
  assign cmd_full  = bit_take & (bits_cnt_reg + 1'b1 == bits_need);
  assign por_hit   = ~por_done_reg & (por_cnt_reg == POR_CYC - 1'b1);

  // counter of low cycles, restarted per bit period
  always_comb begin
    qual_cnt_next = qual_cnt_reg;
    if (start_clr) begin
      qual_cnt_next = '0;
    end else if (bit_end) begin
      qual_cnt_next = '0;
    end else if ((start_reg | start_set) && bus_low && qual_cnt_reg != BIT_LAST) begin
      qual_cnt_next = qual_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // qualification state
  // ----------------------------------------------------------------
  // counter, bit window and lockout timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qual_cnt_reg <= '0;
      win_cnt_reg  <= '0;
      lock_cnt_reg <= '0;
    end else begin
      qual_cnt_reg <= qual_cnt_next;
      win_cnt_reg  <= (~start_reg | start_clr | bit_end) ? '0 : win_cnt_reg + 1'b1;
      lock_cnt_reg <= (~start_reg | start_clr) ? '0 : lock_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_reg <= 1'b0;
    end else if (start_clr) begin
      start_reg <= 1'b0;
    end else if (start_set) begin
      start_reg <= 1'b1;
    end
  end

  // valid and block follow start down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_reg <= 1'b0;
      block_reg <= 1'b0;
    end else if (start_clr) begin
      valid_reg <= 1'b0;
      block_reg <= 1'b0;
    end else begin
      valid_reg <= valid_reg | valid_set;
      block_reg <= block_reg | cmd_full;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt_reg  <= '0;
      por_done_reg <= 1'b0;
    end else if (!por_done_reg) begin
      por_cnt_reg  <= por_cnt_reg + 1'b1;
      por_done_reg <= por_hit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_reg <= 1'b0;
    end else if (start_set) begin
      sample_reg <= 1'b0;
    end else if (por_hit | (start_clr & por_done_reg)) begin
      sample_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // command assembly and hand-off
  // ----------------------------------------------------------------
  // bit shifter and bit counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_reg    <= '0;
      bits_cnt_reg <= '0;
    end else if (start_set) begin
      shift_reg    <= '0;
      bits_cnt_reg <= '0;
    end else if (bit_take) begin
      shift_reg    <= shift_next;
      bits_cnt_reg <= bits_cnt_reg + 1'b1;
    end
  end

  // pass full command to link layer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_reg <= 1'b0;
      cmd_reg  <= '0;
    end else begin
      done_reg <= cmd_full;
      if (cmd_full) begin
        cmd_reg <= shift_next;
      end
    end
  end

  // event counters, cleared by a write; an event in that cycle still counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      good_cnt_reg <= '0;
      bad_cnt_reg  <= '0;
    end else begin
      good_cnt_reg <= (wr_count ? 16'h0000 : good_cnt_reg) + {15'h0000, cmd_full};
      bad_cnt_reg  <= (wr_count ? 16'h0000 : bad_cnt_reg) + {15'h0000, win_fail};
    end
  end

  // gated averaging of the high level
  bcr_vhigh_avg u_avg (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .sample_en   (sample_reg),
    .supply_code (supply_code),
    .ref_code    (vhigh_ref),
    .low_det     (supply_low)
  );

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  // address and data are taken independently, answer after both
  assign aw_take  = axi_req.awvalid & ~aw_hold_reg & ~bvalid_reg;
  assign w_take   = axi_req.wvalid & ~w_hold_reg & ~bvalid_reg;
  assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign ar_take  = axi_req.arvalid & ~rvalid_reg;
  assign wr_ctrl  = do_write & (aw_addr_reg == OFS_CTRL) & w_strb_reg[0];
  assign wr_count = do_write & (aw_addr_reg == OFS_COUNT);
  assign wr_hit   = (aw_addr_reg == OFS_CTRL) | (aw_addr_reg == OFS_COUNT);
  assign rd_hit   = (axi_req.araddr == OFS_CTRL)   | (axi_req.araddr == OFS_STATUS)
                  | (axi_req.araddr == OFS_CMD)    | (axi_req.araddr == OFS_COUNT)
                  | (axi_req.araddr == OFS_VREF);

  // read data selection
  assign rd_mux =
    (axi_req.araddr == OFS_CTRL)   ? {29'h0, ctrl_reg} :
    (axi_req.araddr == OFS_STATUS) ? {24'h0, bits_cnt_reg, start_reg, valid_reg} |
                                     {26'h0, block_reg, sample_reg, 4'h0} & 32'h0 |
                                     {26'h0, block_reg, sample_reg, supply_low,
                                      por_done_reg, 2'h0} :
    (axi_req.araddr == OFS_CMD)    ? cmd_reg :
    (axi_req.araddr == OFS_COUNT)  ? {bad_cnt_reg, good_cnt_reg} :
    (axi_req.araddr == OFS_VREF)   ? {22'h0, vhigh_ref} : 32'h0;

  // write channel holding registers and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= {axi_req.awaddr[7:2], 2'b00};
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= axi_req.wdata;
        w_strb_reg <= axi_req.wstrb;
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (axi_req.bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // control register: mode and receiver enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= w_data_reg[2:0];
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (axi_req.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign axi_rsp.awready = ~aw_hold_reg & ~bvalid_reg;
  assign axi_rsp.wready  = ~w_hold_reg & ~bvalid_reg;
  assign axi_rsp.bvalid  = bvalid_reg;
  assign axi_rsp.bresp   = bresp_reg;
  assign axi_rsp.arready = ~rvalid_reg;
  assign axi_rsp.rvalid  = rvalid_reg;
  assign axi_rsp.rdata   = rdata_reg;
  assign axi_rsp.rresp   = rresp_reg;
  assign rx_flags.start  = start_reg;
  assign rx_flags.valid  = valid_reg;
  assign rx_flags.block  = block_reg;
  assign rx_flags.sample = sample_reg;
  assign cmd_done        = done_reg;
  assign cmd_word        = cmd_reg;
  assign cmd_mode        = mode;

endmodule

/* bench/bcr_receiver_monitor.sv */
// concurrent checks on the receiver ports
`timescale 1ns/100ps
module bcr_receiver_monitor
  import bcr_pkg::*;
#(
  parameter int unsigned POR_DELAY_NS = 1000000,
  parameter int unsigned LOCK_DISC_NS = 400000,
  parameter int unsigned LOCK_CRM_NS  = 300000,
  parameter int unsigned LOCK_PDCM_NS = 60000,
  parameter int unsigned LOCK_BDM_NS  = 60000
)
(
  // clock and reset
  input wire logic         aclk,
  input wire logic         aresetn,
  // register bus
  input wire bcr_axi_req_t axi_req,
  input wire bcr_axi_rsp_t axi_rsp,
  // comparator and supply
  input wire logic         bus_cmp_n,
  input wire logic [9:0]   supply_code,
  // flags, reference and hand-off
  input wire bcr_flags_t   rx_flags,
  input wire logic [9:0]   vhigh_ref,
  input wire logic         supply_low,
  input wire logic         cmd_done,
  input wire logic [31:0]  cmd_word,
  input wire bcr_mode_t    cmd_mode
);
  localparam int POR_C = int'(POR_DELAY_NS * CLK_MHZ / 1000);
  localparam int LK_D  = int'(LOCK_DISC_NS * CLK_MHZ / 1000);
  localparam int LK_C  = int'(LOCK_CRM_NS * CLK_MHZ / 1000);
  localparam int LK_P  = int'(LOCK_PDCM_NS * CLK_MHZ / 1000);
  localparam int LK_B  = int'(LOCK_BDM_NS * CLK_MHZ / 1000);
  int st_cnt;
  int por_cnt;
  int lock_cyc;

  // lockout length of the active mode
  assign lock_cyc = (cmd_mode == BCR_MODE_DISC) ? LK_D :
                    (cmd_mode == BCR_MODE_CRM)  ? LK_C :
                    (cmd_mode == BCR_MODE_PDCM) ? LK_P : LK_B;

  // cycles spent with start high, and cycles since reset release
  always_ff @(posedge aclk) begin
    st_cnt  <= rx_flags.start ? st_cnt + 1 : 0;
    por_cnt <= !aresetn ? 0 : (por_cnt < POR_C ? por_cnt + 1 : por_cnt);
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_handoff;
    cmd_done ##1 !cmd_done;
  endsequence
  sequence s_quiet;
    !rx_flags.sample [*3];
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_start_cause: assert property ($rose(rx_flags.start) |->
    !$past(bus_cmp_n, 2) || !$past(bus_cmp_n, 3) || !$past(bus_cmp_n, 4))
    else $error("start rose without a drop");
  a_valid_count: assert property ($rose(rx_flags.valid) |->
    st_cnt >= int'(VALID_CYC) - 2 && st_cnt <= int'(VALID_CYC))
    else $error("valid at wrong count");
  a_reject_bound: assert property (rx_flags.start && !rx_flags.valid |->
    st_cnt < int'(BIT_CYC)) else $error("short drop not rejected");
  a_lock_bound: assert property (rx_flags.start |-> st_cnt < lock_cyc)
    else $error("start outlived lockout");
  a_block_order: assert property (rx_flags.block |-> rx_flags.valid)
    else $error("block without valid");
  a_flags_clear: assert property ($fell(rx_flags.start) |->
    !rx_flags.valid && !rx_flags.block && rx_flags.sample)
    else $error("flags left set after start");
  a_sample_off: assert property (rx_flags.start |-> !rx_flags.sample)
    else $error("sampling during command");
  a_por_wait: assert property (por_cnt < POR_C - 2 |-> !rx_flags.sample)
    else $error("sampling before power-on delay");
  a_handoff_pulse: assert property ($rose(rx_flags.block) |-> s_handoff)
    else $error("hand-off strobe wrong");
  a_ref_hold: assert property (s_quiet |-> $stable(vhigh_ref))
    else $error("reference moved while not sampling");
  a_low_decide: assert property (1'b1 |=> supply_low ==
    (11'($past(supply_code)) + LOW_MARGIN < $past(vhigh_ref)))
    else $error("low decision wrong");
  a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready &&
    axi_req.wvalid && axi_rsp.wready |=> ##1 axi_rsp.bvalid)
    else $error("write response late");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=>
    axi_rsp.rvalid) else $error("read response late");
endmodule

bind bcr_receiver bcr_receiver_monitor #(
  .POR_DELAY_NS(POR_DELAY_NS), .LOCK_DISC_NS(LOCK_DISC_NS),
  .LOCK_CRM_NS(LOCK_CRM_NS), .LOCK_PDCM_NS(LOCK_PDCM_NS),
  .LOCK_BDM_NS(LOCK_BDM_NS)
) mon (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .bus_cmp_n(bus_cmp_n), .supply_code(supply_code), .rx_flags(rx_flags),
  .vhigh_ref(vhigh_ref), .supply_low(supply_low), .cmd_done(cmd_done),
  .cmd_word(cmd_word), .cmd_mode(cmd_mode)
);

/* bench/bcr_bus_master.sv */
// behavioural bus master driving the comparator level
`timescale 1ns/100ps
module bcr_bus_master
  import bcr_pkg::*;
(
  // clock
  input wire logic aclk,
  // comparator level, high while the bus is high
  output logic     bus_cmp_n
);
  initial bus_cmp_n = 1'b1;

  // one bit slot: drop for low_cyc cycles on a one, idle on a zero
  // drop held for low_cyc cycles, the rest of the slot high
  task automatic send_bit(input logic b, input int low_cyc);
    bus_cmp_n <= ~b;
    repeat (low_cyc) @(posedge aclk);
    bus_cmp_n <= 1'b1;
    repeat (int'(BIT_CYC) - low_cyc) @(posedge aclk);
  endtask

  // whole command, first bit first
  task automatic send_cmd(input int n, input logic [31:0] pat);
    for (int i = n - 1; i >= 0; i--) begin
      send_bit(pat[i], 2 * int'(VALID_CYC));
    end
  endtask
endmodule

/* bench/bus_command_receiver_tb.sv */
// self-checking bench for the bus command receiver
`timescale 1ns/100ps
module bus_command_receiver_tb;
  import bcr_pkg::*;
  logic         aclk, aresetn, bus_cmp_n, supply_low, cmd_done;
  logic [9:0]   supply_code, vhigh_ref;
  logic [31:0]  cmd_word, q;
  logic [1:0]   r;
  bcr_axi_req_t axi_req;
  bcr_axi_rsp_t axi_rsp;
  bcr_flags_t   rx_flags;
  bcr_mode_t    cmd_mode;
  int           error_cnt, comparisons, cyc, t;
  bcr_mode_t    md [4] = '{BCR_MODE_DISC, BCR_MODE_PDCM, BCR_MODE_BDM, BCR_MODE_CRM};
  int           nb [4] = '{1, 4, 4, 32};
  int           lk [4] = '{6000, 6000, 6000, 34000};
  logic [31:0]  pt [4] = '{32'h1, 32'hb, 32'hd, 32'ha5c3_0f81};

  bcr_receiver #(.POR_DELAY_NS(2000), .LOCK_DISC_NS(48000), .LOCK_CRM_NS(272000),
    .LOCK_PDCM_NS(48000), .LOCK_BDM_NS(48000)) dut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .bus_cmp_n(bus_cmp_n), .supply_code(supply_code), .rx_flags(rx_flags),
    .vhigh_ref(vhigh_ref), .supply_low(supply_low), .cmd_done(cmd_done),
    .cmd_word(cmd_word), .cmd_mode(cmd_mode));
  bcr_bus_master master (.aclk(aclk), .bus_cmp_n(bus_cmp_n));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // verdict, compare and bus tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input bcr_flags_t got, input bcr_flags_t exp);
    chk(32'(got), 32'(exp));
  endtask

  // one axi4-lite access; ready is sampled settled, released after the edge
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic aw, w, ar, fin;
    fin = 1'b0;
    @(posedge aclk);
    if (wr) begin
      axi_req.awaddr <= a;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hf;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
    end else begin
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
    end
    while (!fin) begin
      @(negedge aclk);
      aw = axi_req.awvalid && axi_rsp.awready;
      w = axi_req.wvalid && axi_rsp.wready;
      ar = axi_req.arvalid && axi_rsp.arready;
      fin = wr ? axi_rsp.bvalid : axi_rsp.rvalid;
      r = wr ? axi_rsp.bresp : axi_rsp.rresp;
      q = axi_rsp.rdata;
      if (fin) chk(32'(wr ? axi_rsp.awready | axi_rsp.wready : axi_rsp.arready), 32'h0);
      @(posedge aclk);
      if (aw) axi_req.awvalid <= 1'b0;
      if (w) axi_req.wvalid <= 1'b0;
      if (ar) axi_req.arvalid <= 1'b0;
      if (fin) axi_req.bready <= 1'b0;
      if (fin) axi_req.rready <= 1'b0;
    end
  endtask

  // cut a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 90000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    comparisons = 0;
    cyc = 0;
    axi_req = '0;
    supply_code = 10'h200;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (240) @(negedge aclk);
    chk_flags(rx_flags, 4'b0000);
    repeat (20) @(negedge aclk);
    chk_flags(rx_flags, 4'b0001);
    @(posedge aclk);
    axi(1'b0, OFS_CTRL, 32'h0);
    chk(q, 32'(CTRL_RESET));
    axi(1'b1, 8'h40, 32'h7);
    chk(32'(r), 32'(RESP_DECERR));
    axi(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    // receiver still off: a drop must be ignored
    master.send_bit(1'b1, 250);
    chk_flags(rx_flags, 4'b0001);
    axi(1'b1, OFS_CTRL, 32'h6);
    master.send_bit(1'b1, 50);
    repeat (10) @(negedge aclk);
    chk_flags(rx_flags, 4'b0001);
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      axi(1'b1, OFS_CTRL, 32'(md[i]) | 32'h4);
      master.send_cmd(nb[i], pt[i]);
      t = 0;
      while (cmd_done !== 1'b1 && t < 40) begin
        @(negedge aclk);
        t++;
      end
      chk_flags(rx_flags, 4'b1110);
      chk(cmd_word, pt[i]);
      chk(32'(cmd_mode), 32'(md[i]));
      if (i == 0) begin
        @(posedge aclk);
        supply_code <= 10'h100;
        repeat (3) @(negedge aclk);
        chk(32'(supply_low), 32'h1);
        @(posedge aclk);
        supply_code <= 10'h200;
        repeat (3) @(negedge aclk);
        chk(32'(supply_low), 32'h0);
      end
      t = 0;
      while (rx_flags.start === 1'b1 && t < 40000) begin
        @(negedge aclk);
        t++;
      end
      chk_flags(rx_flags, 4'b0001);
      chk(32'(t > lk[i] - nb[i] * 1000 - 12 && t < lk[i] - nb[i] * 1000 + 6), 32'h1);
      @(posedge aclk);
    end
    axi(1'b0, OFS_COUNT, 32'h0);
    chk(q, 32'h0001_0004);
    axi(1'b0, OFS_VREF, 32'h0);
    chk(q, 32'h0000_0200);
    print_verdict();
  end
endmodule
